/* File: pkg/sps_pkg.sv */
`default_nettype none
package sps_pkg;
   // Rate select codes: divide core clock by 2,4,16,32 per half-bit pair
   localparam int unsigned CLK_HZ         = 200_000_000;
   localparam int unsigned SLAVE_MAX_BPS  = 1_000_000;
   localparam int unsigned SLAVE_MIN_CYC  = CLK_HZ / SLAVE_MAX_BPS; // Cycles per slave bit at top rate
   localparam logic [1:0]  RATE_RESET     = 2'h0;
   localparam logic [7:0]  HALF_DIV0      = 8'h01;
   localparam logic [7:0]  HALF_DIV1      = 8'h02;
   localparam logic [7:0]  HALF_DIV2      = 8'h08;
   localparam logic [7:0]  HALF_DIV3      = 8'h10;
   localparam logic [3:0]  BITS_PER_CHAR  = 4'h8;
   localparam logic [7:0]  DATA_RESET     = 8'h00;

   typedef enum logic [2:0] {
      SPS_IDLE = 3'b001,
      SPS_LEAD = 3'b010,
      SPS_TRAIL = 3'b100
   } sps_state_e;

   // Software controls gathered together
   typedef struct packed {
      logic       blockEnable;     // serial_block_enable_bit
      logic       masterSelect;    // master_select_bit
      logic       clockPolarity;   // clock_polarity_bit
      logic       clockPhase;      // clock_phase_bit
      logic [1:0] rateSelect;
      logic       selectPinDir;    // select_pin_direction_bit
   } sps_ctrl_s;

   // Status flags shown to software
   typedef struct packed {
      logic transferDone;
      logic writeCollision;
      logic modeFault;
      logic overrun;
   } sps_stat_s;
endpackage : sps_pkg
`default_nettype wire

/* File: design/sps_pin_sync.sv */
`default_nettype none
module sps_pin_sync (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       clkEn,
   input  wire logic [2:0] pinIn,
   output logic      [2:0] pinOut
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] q;
   } sps_sync_s;
   sps_sync_s st_r;
   sps_sync_s st_nxt;

   // Change accepted only once stages two and three agree
   always_comb begin
      st_nxt    = st_r;
      st_nxt.s1 = pinIn;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      for (int i = 0; i < 3; i++) begin
         if (st_r.s2[i] == st_r.s3[i]) begin
            st_nxt.q[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{s1: 3'h7, s2: 3'h7, s3: 3'h7, q: 3'h7};
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end
   assign pinOut = st_r.q;
endmodule : sps_pin_sync
`default_nettype wire

/* File: design/sps_rate_div.sv */
`default_nettype none
module sps_rate_div (
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   input  wire logic       clkEn,
   input  wire logic       run,
   input  wire logic [1:0] rateSelect,
   output logic            halfTick
);
   logic [7:0] cnt_r;
   logic [7:0] limit;
   logic       tick_r;

   // Four software-selectable master rates
   always_comb begin
      case (rateSelect)
         2'h0:    limit = sps_pkg::HALF_DIV0;
         2'h1:    limit = sps_pkg::HALF_DIV1;
         2'h2:    limit = sps_pkg::HALF_DIV2;
         default: limit = sps_pkg::HALF_DIV3;
      endcase
   end

   // Counter held clear outside transfers so each starts aligned
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r  <= 8'h00;
         tick_r <= 1'b0;
      end else if (clkEn) begin
         if (!run) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b0;
         end else if (cnt_r + 8'h01 >= limit) begin
            cnt_r  <= 8'h00;
            tick_r <= 1'b1;
         end else begin
            cnt_r  <= cnt_r + 8'h01;
            tick_r <= 1'b0;
         end
      end
   end
   assign halfTick = tick_r;
endmodule : sps_rate_div
`default_nettype wire

/* File: design/sps_core.sv */
`default_nettype none
module sps_core (
   input  wire logic              core_clk,
   input  wire logic              reset_n,
   input  wire logic              clkEn,
   input  wire sps_pkg::sps_ctrl_s ctrl,
   input  wire logic              dataWrite,
   input  wire logic [7:0]        dataWdata,
   input  wire logic              dataRead,
   input  wire logic              statusRead,
   output logic [7:0]             dataRdata,
   output sps_pkg::sps_stat_s     status,
   input  wire logic              sckIn,
   output logic                   sckOut,
   output logic                   sckOe_n,
   input  wire logic              mosiIn,
   output logic                   mosiOut,
   output logic                   mosiOe_n,
   input  wire logic              misoIn,
   output logic                   misoOut,
   output logic                   misoOe_n,
   input  wire logic              selectIn_n
);
   typedef struct packed {
      sps_pkg::sps_state_e state;
      logic [7:0]          shifter;
      logic [7:0]          readBuf;
      logic                bufFull;
      logic                sampled;
      logic [3:0]          bitCnt;
      logic                sck;
      logic                busy;
      logic                prevSck;
      sps_pkg::sps_stat_s  stat;
      logic                sckOe_n;
      logic                mosiOut;
      logic                mosiOe_n;
      logic                misoOe_n;
   } sps_core_s;

   sps_core_s st_r;
   sps_core_s st_nxt;
   logic [2:0] syncPins;
   logic       sckS;
   logic       dinS;
   logic       selS_n;
   logic       halfTick;
   logic       isMaster;
   logic       isSlave;
   logic       slvSelected;
   logic       leadEdge;
   logic       trailEdge;

   // External pins pass the three-stage filter
   // Filter delay of about four cycles limits master receive to the two slower rates
   sps_pin_sync u_sync (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clkEn    (clkEn),
      .pinIn    ({sckIn, selectIn_n, ctrl.masterSelect ? misoIn : mosiIn}),
      .pinOut   (syncPins)
   );
   assign sckS   = syncPins[2];
   assign selS_n = syncPins[1];
   assign dinS   = syncPins[0];

   sps_rate_div u_div (
      .core_clk   (core_clk),
      .reset_n    (reset_n),
      .clkEn      (clkEn),
      .run        (st_r.busy & isMaster),
      .rateSelect (ctrl.rateSelect),
      .halfTick   (halfTick)
   );

   assign isMaster    = ctrl.blockEnable & ctrl.masterSelect & ~st_r.stat.modeFault;
   assign isSlave     = ctrl.blockEnable & ~ctrl.masterSelect;
   assign slvSelected = isSlave & ~selS_n;
   // Slave edges: leading edge leaves idle level set by polarity
   assign leadEdge  = (sckS != st_r.prevSck) & (sckS != ctrl.clockPolarity);
   assign trailEdge = (sckS != st_r.prevSck) & (sckS == ctrl.clockPolarity);

   always_comb begin
      st_nxt         = st_r;
      st_nxt.prevSck = sckS;
      // Idle clock rests at the polarity level, so a setting change between transfers
      // never shows up as a stray edge at the start of the next one
      if (!st_r.busy) begin
         st_nxt.sck = ctrl.clockPolarity;
      end
      // Flags clear on status read, but a same-cycle event wins
      if (statusRead) begin
         st_nxt.stat = '0;
      end
      if (dataRead) begin
         st_nxt.bufFull = 1'b0;
      end
      // Mode fault from a competing master
      if (ctrl.blockEnable & ctrl.masterSelect & ~ctrl.selectPinDir & ~selS_n) begin
         st_nxt.stat.modeFault = 1'b1;
         st_nxt.busy           = 1'b0;
         st_nxt.state          = sps_pkg::SPS_IDLE;
         st_nxt.sck            = ctrl.clockPolarity;
      end
      // Write to the data address loads shifter unless a transfer runs or a phase-zero slave is selected
      if (dataWrite) begin
         if (st_r.busy | (isSlave & ~ctrl.clockPhase & ~selS_n)) begin
            st_nxt.stat.writeCollision = 1'b1;
         end else begin
            st_nxt.shifter = dataWdata;
            if (isMaster) begin
               st_nxt.busy   = 1'b1;
               st_nxt.bitCnt = 4'h0;
               st_nxt.state  = sps_pkg::SPS_LEAD;
               st_nxt.sck    = ctrl.clockPolarity;
               // Phase zero presents first bit before any edge
               if (!ctrl.clockPhase) begin
                  st_nxt.mosiOut = dataWdata[7];
               end
            end
         end
      end
      // Master sequencer: each half bit alternates lead and trail edges
      if (isMaster & st_r.busy & halfTick) begin
         case (st_r.state)
            sps_pkg::SPS_LEAD: begin
               st_nxt.sck   = ~ctrl.clockPolarity;
               st_nxt.state = sps_pkg::SPS_TRAIL;
               if (ctrl.clockPhase) begin
                  st_nxt.mosiOut = st_r.shifter[7];
               end else begin
                  st_nxt.sampled = dinS;
               end
            end
            sps_pkg::SPS_TRAIL: begin
               st_nxt.sck   = ctrl.clockPolarity;
               st_nxt.state = sps_pkg::SPS_LEAD;
               if (ctrl.clockPhase) begin
                  st_nxt.shifter = {st_r.shifter[6:0], dinS};
               end else begin
                  st_nxt.shifter = {st_r.shifter[6:0], st_r.sampled};
                  st_nxt.mosiOut = st_r.shifter[6];
               end
               st_nxt.bitCnt = st_r.bitCnt + 4'h1;
               if (st_r.bitCnt + 4'h1 == sps_pkg::BITS_PER_CHAR) begin
                  st_nxt.busy  = 1'b0;
                  st_nxt.state = sps_pkg::SPS_IDLE;
               end
            end
            default: st_nxt.state = sps_pkg::SPS_IDLE;
         endcase
      end
      // Slave shifting follows the filtered external clock
      if (slvSelected) begin
         if (leadEdge) begin
            st_nxt.busy = 1'b1;
            if (ctrl.clockPhase) begin
               st_nxt.mosiOut = st_r.shifter[7];
            end else begin
               st_nxt.sampled = dinS;
            end
         end
         if (trailEdge & st_r.busy) begin
            if (ctrl.clockPhase) begin
               st_nxt.shifter = {st_r.shifter[6:0], dinS};
            end else begin
               st_nxt.shifter = {st_r.shifter[6:0], st_r.sampled};
               st_nxt.mosiOut = st_r.shifter[6];
            end
            st_nxt.bitCnt = st_r.bitCnt + 4'h1;
            if (st_r.bitCnt + 4'h1 == sps_pkg::BITS_PER_CHAR) begin
               st_nxt.busy   = 1'b0;
               st_nxt.bitCnt = 4'h0;
            end
         end else if (!st_r.busy & !ctrl.clockPhase) begin
            st_nxt.mosiOut = st_r.shifter[7];
         end
      end else if (isSlave) begin
         st_nxt.bitCnt = 4'h0;
         st_nxt.busy   = 1'b0;
      end
      // Completed character moves into the read buffer
      if (st_r.busy & ~st_nxt.busy & (st_nxt.bitCnt == sps_pkg::BITS_PER_CHAR | isSlave)
          & ~st_nxt.stat.modeFault) begin
         st_nxt.readBuf           = st_nxt.shifter;
         st_nxt.stat.transferDone = 1'b1;
         st_nxt.stat.overrun      = st_nxt.stat.overrun | (st_r.bufFull & ~dataRead);
         st_nxt.bufFull           = 1'b1;
      end
      // Driver enables, active low
      st_nxt.sckOe_n  = ~isMaster | st_nxt.stat.modeFault;
      st_nxt.mosiOe_n = ~isMaster | st_nxt.stat.modeFault;
      st_nxt.misoOe_n = ~slvSelected;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= '{state: sps_pkg::SPS_IDLE, shifter: sps_pkg::DATA_RESET,
                   readBuf: sps_pkg::DATA_RESET, bufFull: 1'b0, sampled: 1'b0,
                   bitCnt: 4'h0, sck: 1'b0, busy: 1'b0, prevSck: 1'b1,
                   stat: '0, sckOe_n: 1'b1, mosiOut: 1'b0,
                   mosiOe_n: 1'b1, misoOe_n: 1'b1};
      end else if (clkEn) begin
         st_r <= st_nxt;
      end
   end

   // Outputs all come from the state register
   assign dataRdata = st_r.readBuf;
   assign status    = st_r.stat;
   assign sckOut    = st_r.sck;
   assign sckOe_n   = st_r.sckOe_n;
   assign mosiOut   = st_r.mosiOut;
   assign mosiOe_n  = st_r.mosiOe_n;
   assign misoOut   = st_r.mosiOut;
   assign misoOe_n  = st_r.misoOe_n;

   // Checks: driver enables and faults
   // A status read in the same cycle may clear the fault, so it is left out of the trigger
   a_fault_drops_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & st_r.stat.modeFault & ~statusRead |=> st_r.sckOe_n & st_r.mosiOe_n)
      else $error("drivers active after mode fault");
   a_unsel_floats: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & ~slvSelected |=> st_r.misoOe_n)
      else $error("slave drives data while unselected");
   a_slave_no_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & isSlave |=> st_r.sckOe_n & st_r.mosiOe_n)
      else $error("slave drives master lines");
   a_fault_on_select: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & ctrl.blockEnable & ctrl.masterSelect & ~ctrl.selectPinDir & ~selS_n
      |=> st_r.stat.modeFault)
      else $error("mode fault missed");

   // Checks: write path and collisions
   a_busy_write_collides: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & dataWrite & st_r.busy |=> st_r.stat.writeCollision)
      else $error("collision not flagged");
   a_busy_keeps_shifter: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & dataWrite & st_r.busy & ~halfTick & ~slvSelected |=> $stable(st_r.shifter))
      else $error("shifter loaded during transfer");
   a_phase0_collide: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & dataWrite & isSlave & ~ctrl.clockPhase & ~selS_n |=> st_r.stat.writeCollision)
      else $error("phase zero slave collision missed");
   a_write_loads_shifter: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & dataWrite & ~st_r.busy & ~(isSlave & ~ctrl.clockPhase & ~selS_n)
      |=> st_r.shifter == $past(dataWdata))
      else $error("idle write did not load shifter");

   // Checks: bit counting, clock and receive buffer
   a_eight_bits_max: assert property (@(posedge core_clk) disable iff (!reset_n)
      st_r.bitCnt <= sps_pkg::BITS_PER_CHAR)
      else $error("bit count past eight");
   a_slave_idle_count: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & isSlave & selS_n |=> ~st_r.busy & (st_r.bitCnt == 4'h0))
      else $error("unselected slave kept counting");
   a_idle_sck_level: assert property (@(posedge core_clk) disable iff (!reset_n)
      isMaster & ~st_r.busy & $stable(ctrl.clockPolarity) & clkEn
      ##1 clkEn & ~st_r.busy & $stable(ctrl.clockPolarity)
      |-> st_r.sck == ctrl.clockPolarity)
      else $error("idle clock level wrong");
   a_done_fills_buffer: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & $rose(st_r.stat.transferDone) |-> st_r.bufFull)
      else $error("completion without buffered data");
   a_readbuf_holds: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & ~st_r.busy |=> $stable(st_r.readBuf))
      else $error("read buffer changed outside a transfer");
   a_overrun_sticky: assert property (@(posedge core_clk) disable iff (!reset_n)
      clkEn & st_r.stat.overrun & ~statusRead |=> st_r.stat.overrun)
      else $error("overrun lost before status read");

   // Main scenarios
   c_master_done: cover property (@(posedge core_clk) isMaster & $fell(st_r.busy));
   c_slave_done: cover property (@(posedge core_clk) isSlave & $rose(st_r.stat.transferDone));
   c_mode_fault: cover property (@(posedge core_clk) $rose(st_r.stat.modeFault));
   c_overrun: cover property (@(posedge core_clk) $rose(st_r.stat.overrun));
   c_collision: cover property (@(posedge core_clk) $rose(st_r.stat.writeCollision));
endmodule : sps_core
`default_nettype wire

/* File: tb/sps_slave_model.sv */
`default_nettype none
module sps_slave_model (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       selN,
   input  wire logic       clock_polarity_bit,
   input  wire logic       clock_phase_bit,
   input  wire logic [7:0] txByte,
   output logic            miso,
   output logic [7:0]      rxByte,
   output logic [7:0]      edgeCnt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] shifter;
   logic       lead;
   initial begin
      miso = 1'b0;
      rxByte = 8'h00;
      edgeCnt = 8'h00;
      shifter = 8'h00;
      lead = 1'b0;
   end
   // Selection loads the reply; phase zero shows its first bit at once
   always @(negedge selN) begin
      shifter = txByte;
      edgeCnt = 8'h00;
      if (!clock_phase_bit) miso = shifter[7];
   end
   // Released line must not look like held data
   always @(posedge selN) miso = ~miso;
   // Same phase and polarity as the master is assumed here
   always @(sck) begin
      if (!selN) begin
         edgeCnt = edgeCnt + 8'h01;
         lead = (sck != clock_polarity_bit);
         if (lead != clock_phase_bit) begin
            shifter = {shifter[6:0], mosi};
            rxByte = shifter;
         end else begin
            miso = shifter[7];
         end
      end
   end
endmodule : sps_slave_model
`default_nettype wire

/* File: tb/testbench.sv */
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
   $display("wrong value at %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic               core_clk = 1'b0, reset_n = 1'b0, clkEn = 1'b1;
   sps_pkg::sps_ctrl_s ctrl = '0;
   logic               dataWrite = 1'b0, dataRead = 1'b0, statusRead = 1'b0;
   logic [7:0]         dataWdata = 8'h00, dataRdata, sTx = 8'h00, mTx, got, rxByte, edgeCnt;
   sps_pkg::sps_stat_s status;
   logic               sckIn = 1'b0, mosiIn = 1'b0, selectIn_n = 1'b1, selN = 1'b1;
   logic               sckOut, sckOe_n, mosiOut, mosiOe_n, misoIn, misoOut, misoOe_n, doneD = 1'b0;
   logic [31:0]        lfsrState = 32'h84241f89;
   logic [8:0]         expQ[$];
   logic [8:0]         e;
   int                 err_count = 0, comparisons = 0;
   always #2.5 core_clk = ~core_clk;
   sps_core uut (.core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .ctrl(ctrl), .dataWrite(dataWrite),
      .dataWdata(dataWdata), .dataRead(dataRead), .statusRead(statusRead), .dataRdata(dataRdata),
      .status(status), .sckIn(sckIn), .sckOut(sckOut), .sckOe_n(sckOe_n), .mosiIn(mosiIn),
      .mosiOut(mosiOut), .mosiOe_n(mosiOe_n), .misoIn(misoIn), .misoOut(misoOut), .misoOe_n(misoOe_n),
      .selectIn_n(selectIn_n));
   sps_slave_model peer (.sck(sckOut), .mosi(mosiOut), .selN(selN), .clock_polarity_bit(ctrl.clockPolarity),
      .clock_phase_bit(ctrl.clockPhase), .txByte(sTx), .miso(misoIn), .rxByte(rxByte), .edgeCnt(edgeCnt));
   function logic [7:0] lfsr();
      lfsrState = {lfsrState[30:0], ^(lfsrState & 32'h80200003)};
      return lfsrState[7:0];
   endfunction : lfsr
   task end_of_test();
      $display("errors %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : end_of_test
   task wr(input logic [7:0] d);
      dataWdata = d;
      dataWrite = 1'b1;
      @(negedge core_clk) dataWrite = 1'b0;
   endtask : wr
   // Status first, then the buffer, one cycle apart
   task clr();
      statusRead = 1'b1;
      @(negedge core_clk) statusRead = 1'b0;
      dataRead = 1'b1;
      @(negedge core_clk) dataRead = 1'b0;
   endtask : clr
   task waitDone();
      int k;
      for (k = 0; k < 4000 && status.transferDone !== 1'b1; k++) @(negedge core_clk);
      if (k == 4000) begin
         err_count++;
         end_of_test();
      end
   endtask : waitDone
   // Bench as master at the top slave rate; phase zero sets data half a bit before the leading edge
   task sxfer(input logic [7:0] m, output logic [7:0] s);
      for (int b = 7; b >= 0; b--) begin
         if (!ctrl.clockPhase) begin
            mosiIn = m[b];
            repeat (sps_pkg::SLAVE_MIN_CYC / 2) @(negedge core_clk);
            s[b] = misoOut;
         end
         sckIn = ~ctrl.clockPolarity;
         if (ctrl.clockPhase) begin
            mosiIn = m[b];
         end
         repeat (sps_pkg::SLAVE_MIN_CYC / 2) @(negedge core_clk);
         if (ctrl.clockPhase) begin
            s[b] = misoOut;
         end
         sckIn = ctrl.clockPolarity;
         if (ctrl.clockPhase) begin
            repeat (sps_pkg::SLAVE_MIN_CYC / 2) @(negedge core_clk);
         end
      end
      mosiIn = ~mosiIn;
   endtask : sxfer
   // Result watcher: takes one note per completed character
   always @(posedge core_clk) doneD <= status.transferDone;
   always @(negedge core_clk) begin
      if (status.transferDone === 1'b1 && doneD === 1'b0 && expQ.size() > 0) begin
         e = expQ.pop_front();
         if (e[8]) `CHK(dataRdata, e[7:0])
      end
   end
   initial begin
      repeat (12) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (6) @(negedge core_clk);
      // Master: every phase/polarity pair at every rate
      for (int i = 0; i < 16; i++) begin
         // Select settles high before the pin turns back into a fault input
         selectIn_n = 1'b1;
         repeat (6) @(negedge core_clk);
         ctrl = '{1'b1, 1'b1, i[1], i[0], i[3:2], i[2]};
         selectIn_n = !i[2];
         repeat (6) @(negedge core_clk);
         `CHK({sckOut, sckOe_n, mosiOe_n}, {i[1], 2'b00})
         sTx = lfsr();
         selN = 1'b0;
         repeat (2) @(negedge core_clk);
         mTx = lfsr();
         expQ.push_back({i[3], sTx}); // fastest rates shorter than the input filter
         wr(mTx);
         // Clock enable low freezes the transfer just after it starts, before its first clock edge
         if (i == 10) begin
            clkEn = 1'b0;
            got = edgeCnt;
            repeat (20) @(negedge core_clk);
            `CHK(edgeCnt, got)
            clkEn = 1'b1;
         end
         if (i == 5) begin
            repeat (3) @(negedge core_clk);
            wr(~mTx);
         end
         waitDone();
         `CHK({edgeCnt, rxByte}, {8'h10, mTx})
         if (i == 5) `CHK(status.writeCollision, 1'b1)
         clr();
         selN = 1'b1;
      end
      // Competing master pulls the select input low
      ctrl.selectPinDir = 1'b0;
      selectIn_n = 1'b0;
      repeat (8) @(negedge core_clk);
      `CHK({status.modeFault, sckOe_n, mosiOe_n}, 3'b111)
      selectIn_n = 1'b1;
      repeat (6) @(negedge core_clk);
      clr();
      `CHK(status.modeFault, 1'b0)
      // Unselected slave sees clocks but stays off the bus
      ctrl = '{1'b1, 1'b0, 1'b0, 1'b1, 2'h0, 1'b0};
      repeat (16) begin
         sckIn = ~sckIn;
         mosiIn = lfsrState[0];
         repeat (4) @(negedge core_clk) void'(lfsr());
      end
      `CHK({misoOe_n, status.transferDone}, 2'b10)
      // Phase one slave, select held low across two characters
      selectIn_n = 1'b0;
      for (int j = 0; j < 2; j++) begin
         sTx = lfsr();
         wr(sTx);
         mTx = lfsr();
         expQ.push_back({1'b1, mTx});
         repeat (6) @(negedge core_clk);
         sxfer(mTx, got);
         `CHK(got, sTx)
         waitDone();
         `CHK(status.overrun, 1'b0)
         clr();
      end
      // Phase zero slave, inverted clock, select raised between characters
      selectIn_n = 1'b1;
      ctrl.clockPhase = 1'b0;
      ctrl.clockPolarity = 1'b1;
      sckIn = 1'b1;
      for (int j = 0; j < 2; j++) begin
         repeat (6) @(negedge core_clk);
         sTx = lfsr();
         wr(sTx);
         mTx = lfsr();
         expQ.push_back({1'b1, mTx});
         selectIn_n = 1'b0;
         repeat (6) @(negedge core_clk);
         sxfer(mTx, got);
         `CHK(got, sTx)
         waitDone();
         // First character left unread so the second one overruns
         if (j == 0) begin
            statusRead = 1'b1;
            @(negedge core_clk) statusRead = 1'b0;
         end else begin
            `CHK(status.overrun, 1'b1)
            clr();
         end
         selectIn_n = 1'b1;
      end
      // Phase zero slave written while selected
      repeat (6) @(negedge core_clk);
      selectIn_n = 1'b0;
      repeat (6) @(negedge core_clk);
      wr(8'h5a);
      repeat (2) @(negedge core_clk);
      `CHK(status.writeCollision, 1'b1)
      end_of_test();
   end
endmodule : testbench
`default_nettype wire
